// file: cfgd_pkg.sv
// Constants, field layout and carrier types for the configuration word decoder.
// Assumes 24-bit program-once words presented as static levels from the fuse array.
package cfgd_pkg;

	typedef logic [23:0] cfgd_word_t;
	typedef logic [7:0]  cfgd_addr_t;

	// Register byte addresses
	localparam cfgd_addr_t CFGD_ADDR_SEC      = 8'h00;
	localparam cfgd_addr_t CFGD_ADDR_BOOT_PAGE_LIMIT_INVERTED    = 8'h04;
	localparam cfgd_addr_t CFGD_ADDR_SIGN     = 8'h08;
	localparam cfgd_addr_t CFGD_ADDR_OSCSEL   = 8'h0C;
	localparam cfgd_addr_t CFGD_ADDR_S_OSCSEL = 8'h10;
	localparam cfgd_addr_t CFGD_ADDR_S_OSC    = 8'h14;
	localparam cfgd_addr_t CFGD_ADDR_S_WDT    = 8'h18;
	localparam cfgd_addr_t CFGD_ADDR_S_POR    = 8'h1C;
	localparam cfgd_addr_t CFGD_ADDR_S_DBG    = 8'h20;
	localparam cfgd_addr_t CFGD_ADDR_S_DEVOPT = 8'h24;
	localparam cfgd_addr_t CFGD_ADDR_S_CTXT   = 8'h28;
	localparam cfgd_addr_t CFGD_ADDR_STATUS   = 8'h2C;

	// Implemented (and reserved) positions; all others read back as one
	localparam cfgd_word_t CFGD_IMPL_SEC      = 24'h00_8FEF;
	localparam cfgd_word_t CFGD_IMPL_BOOT_PAGE_LIMIT_INVERTED    = 24'h00_1FFF;
	localparam cfgd_word_t CFGD_IMPL_SIGN     = 24'h00_8000;
	localparam cfgd_word_t CFGD_IMPL_OSCSEL   = 24'h00_0087;
	localparam cfgd_word_t CFGD_IMPL_S_OSC    = 24'h00_01C4;
	localparam cfgd_word_t CFGD_IMPL_S_WDT    = 24'h00_FFFF;
	localparam cfgd_word_t CFGD_IMPL_S_POR    = 24'h00_0000;
	localparam cfgd_word_t CFGD_IMPL_S_DBG    = 24'h00_A083;
	localparam cfgd_word_t CFGD_IMPL_S_DEVOPT = 24'h00_E008;
	localparam cfgd_word_t CFGD_IMPL_S_CTXT   = 24'h00_7777;

	// Field positions
	localparam int CFGD_SEC_ALTERNATE_VECTOR_TABLE_DIS   = 15;
	localparam int CFGD_SEC_CSS_LSB    = 9;
	localparam int CFGD_SEC_CWP        = 8;
	localparam int CFGD_SEC_GSS_LSB    = 6;
	localparam int CFGD_SEC_GWP        = 5;
	localparam int CFGD_SEC_BABSENT    = 3;
	localparam int CFGD_SEC_BSS_LSB    = 1;
	localparam int CFGD_SEC_BWP        = 0;
	localparam int CFGD_BOOT_PAGE_LIMIT_INVERTED_MSB      = 12;
	localparam int CFGD_SIGN_RSVD      = 15;
	localparam int CFGD_OSC_TWO_SPEED  = 7;
	localparam int CFGD_OSC_SRC_LSB    = 0;
	localparam int CFGD_S_CKSM_LSB     = 6;
	localparam int CFGD_S_OSCIO        = 2;
	localparam int CFGD_S_NO_SWAP      = 15;
	localparam int CFGD_S_ISOLATE      = 13;
	localparam int CFGD_S_DBG_LSB      = 0;
	localparam int CFGD_S_CTXT_STRIDE  = 4;
	localparam int CFGD_S_CTXT_COUNT   = 4;

	// Status register bits
	localparam int CFGD_ST_VALID       = 0;
	localparam int CFGD_ST_WR_REFUSED  = 1;
	localparam int CFGD_ST_SIGN_BAD    = 2;
	localparam int CFGD_ST_OSC_RSVD    = 3;
	localparam int CFGD_ST_S_OSC_RSVD  = 4;

	// Synchroniser fill before the first stability check
	localparam logic [1:0] CFGD_FILL_CYC = 2'h3;

	typedef enum logic [1:0] {
		CFGD_SEC_NONE,
		CFGD_SEC_STANDARD,
		CFGD_SEC_ENHANCED,
		CFGD_SEC_HIGH
	} cfgd_sec_level_e;

	typedef enum logic [2:0] {
		CFGD_OSC_FAST_RC_POSTSCALE,
		CFGD_OSC_BACKUP_FAST_RC,
		CFGD_OSC_LOW_POWER_RC,
		CFGD_OSC_RESERVED,
		CFGD_OSC_PRIMARY_PLL,
		CFGD_OSC_PRIMARY,
		CFGD_OSC_FAST_RC_PLL,
		CFGD_OSC_FAST_RC
	} cfgd_osc_src_e;

	typedef struct packed {
		cfgd_word_t code_protection_word;
		cfgd_word_t boot_limit_word;
		cfgd_word_t signature_word;
		cfgd_word_t oscillator_select_word;
		cfgd_word_t second_core_oscillator_select_word;
		cfgd_word_t second_core_oscillator_word;
		cfgd_word_t second_core_watchdog_word;
		cfgd_word_t second_core_power_on_word;
		cfgd_word_t second_core_debug_word;
		cfgd_word_t second_core_device_option_word;
		cfgd_word_t second_core_context_assign_word;
	} cfgd_words_s;

	typedef struct packed {
		cfgd_addr_t addr;
		cfgd_word_t wdata;
		logic       wr;
		logic       rd;
	} cfgd_bus_req_s;

	typedef struct packed {
		logic            alternate_vector_table_enable;
		cfgd_sec_level_e cfg_segment_security_level;
		logic            cfg_segment_write_protected;
		cfgd_sec_level_e general_segment_security_level;
		logic            general_segment_write_protected;
		logic            boot_segment_absent;
		cfgd_sec_level_e boot_segment_security_level;
		logic            boot_segment_write_protected;
		logic [12:0]     boot_first_general_page;
		logic            two_speed_startup_enable;
		cfgd_osc_src_e   initial_osc_source;
	} cfgd_prim_ctrl_s;

	typedef struct packed {
		cfgd_osc_src_e   initial_osc_source;
		logic            two_speed_startup_enable;
		logic [1:0]      clock_switch_mode;
		logic            osc_pin_clock_out;
		logic            second_core_no_boot_swap;
		logic            second_core_isolation;
		logic [1:0]      second_core_debug_channel;
		logic [3:0][2:0] second_core_context_assign;
	} cfgd_sec_ctrl_s;

endpackage

// file: cfgd_sync3.sv
// Three-stage synchroniser for a vector of static fuse levels.
// Assumes the source changes rarely; stable means stages two and three agree.
`timescale 1ns/100ps
module cfgd_sync3 #(
	parameter int W = 8
) (
	input  wire logic         clk_sys,
	input  wire logic         rst,
	input  wire logic [W-1:0] din,
	output logic      [W-1:0] dout,
	output logic              stable
);

	logic [W-1:0] meta_reg;
	logic [W-1:0] s2_reg;
	logic [W-1:0] s3_reg;

	// First stage feeds only the second
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			meta_reg <= '0;
			s2_reg   <= '0;
			s3_reg   <= '0;
		end else begin
			meta_reg <= din;
			s2_reg   <= meta_reg;
			s3_reg   <= s2_reg;
		end
	end

	assign dout   = s3_reg;
	assign stable = (s2_reg == s3_reg);

endmodule

// file: cfgd_decode.sv
// Configuration word decoder: captures program-once words after reset and drives
// protection and vector table controls for the primary core and start-up clock controls for both cores.
// Assumes fuse levels are static pins and a simple strobe register port.
//
// Summary of operation
// R1 - Vector-table-disable bit one turns alternate table off; zero turns it on.
// R2 - Config segment level: 111 none, 110 standard, 10x enhanced, 0xx high.
// R3 - Config segment write-protected while its protect bit is zero.
// R4 - General segment level: 11 none, 10 standard, 0x high.
// R5 - General segment write-protected while its protect bit is zero.
// R6 - Boot-enable bit one means no boot segment; zero uses the limit field.
// R7 - Boot segment level: 11 none, 10 standard, 0x high.
// R8 - Boot segment write-protected while its protect bit is zero.
// R9 - Boot limit field stores inverted page address; decoder inverts it back.
// R10 - Switchover bit one enables two-speed start-up; zero disables it.
// R11 - Three-bit field picks the initial oscillator; 100 is reserved.
// R12 - Unimplemented positions read back as one; reserved ones stay stored.
// R13 - Programmer keeps signature bit 15 at zero; other bits unimplemented.
// R14 - Bits read as erased ones until programmed; running code cannot rewrite.
// R15 - Second core has its own oscillator, debug, isolation and context words.
// R16 - Words sampled once after reset; outputs then hold until next reset.
`timescale 1ns/100ps
module cfgd_decode
	import cfgd_pkg::*;
(
	input  wire logic            clk_sys,
	input  wire logic            rst,
	input  wire cfgd_words_s     cfg_words,
	input  wire cfgd_bus_req_s   bus_req,
	output cfgd_word_t           bus_rdata,
	output cfgd_prim_ctrl_s      prim_ctrl,
	output cfgd_sec_ctrl_s       sec_ctrl,
	output logic                 cfg_valid
);

	typedef enum logic [1:0] {
		CFGD_ST_FILL,
		CFGD_ST_CAPTURE,
		CFGD_ST_DECODE,
		CFGD_ST_HOLD
	} cfgd_state_e;

	cfgd_state_e     state_reg;
	cfgd_state_e     state_next;
	logic [1:0]      fill_cnt_reg;
	cfgd_words_s     sync_words;
	logic            sync_stable;
	cfgd_words_s     words_reg;
	cfgd_word_t      bus_rdata_reg;
	cfgd_word_t      rd_mux;
	cfgd_prim_ctrl_s prim_ctrl_reg;
	cfgd_sec_ctrl_s  sec_ctrl_reg;
	cfgd_sec_ctrl_s  sec_decoded;
	logic            valid_reg;
	logic            wr_refused_reg;
	logic            sign_bad_reg;
	logic            osc_rsvd_reg;
	logic            s_osc_rsvd_reg;
	logic            status_clr_hit;
	logic            wr_other_hit;

	// Two-bit protection level shared by general and boot segments
	function automatic cfgd_sec_level_e level2(input logic [1:0] f);
		cfgd_sec_level_e lv;
		lv = CFGD_SEC_HIGH;
		if (f == 2'b11) begin
			lv = CFGD_SEC_NONE;
		end else if (f == 2'b10) begin
			lv = CFGD_SEC_STANDARD;
		end
		return lv;
	endfunction

	function automatic cfgd_sec_level_e level3(input logic [2:0] f);
		cfgd_sec_level_e lv;
		lv = CFGD_SEC_HIGH;
		if (f == 3'b111) begin
			lv = CFGD_SEC_NONE;
		end else if (f == 3'b110) begin
			lv = CFGD_SEC_STANDARD;
		end else if (f[2]) begin
			lv = CFGD_SEC_ENHANCED;
		end
		return lv;
	endfunction

	function automatic cfgd_osc_src_e osc_decode(input logic [2:0] f);
		cfgd_osc_src_e src;
		src = CFGD_OSC_FAST_RC;
		unique case (f)
			3'b111: src = CFGD_OSC_FAST_RC_POSTSCALE;
			3'b110: src = CFGD_OSC_BACKUP_FAST_RC;
			3'b101: src = CFGD_OSC_LOW_POWER_RC;
			3'b100: src = CFGD_OSC_RESERVED;
			3'b011: src = CFGD_OSC_PRIMARY_PLL;
			3'b010: src = CFGD_OSC_PRIMARY;
			3'b001: src = CFGD_OSC_FAST_RC_PLL;
			3'b000: src = CFGD_OSC_FAST_RC;
		endcase
		return src;
	endfunction

	// Unimplemented positions forced high on readback
	function automatic cfgd_word_t readback(input cfgd_word_t w, input cfgd_word_t impl);
		return w | ~impl;
	endfunction

	// Fuse levels come from outside the clock domain
	cfgd_sync3 #(
		.W ($bits(cfgd_words_s))
	) u_sync (
		.clk_sys (clk_sys),
		.rst     (rst),
		.din     (cfg_words),
		.dout    (sync_words),
		.stable  (sync_stable)
	);

	// R16 one-shot capture
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			CFGD_ST_FILL: begin
				if (fill_cnt_reg == CFGD_FILL_CYC && sync_stable) begin
					state_next = CFGD_ST_CAPTURE;
				end
			end
			CFGD_ST_CAPTURE: state_next = CFGD_ST_DECODE;
			CFGD_ST_DECODE:  state_next = CFGD_ST_HOLD;
			CFGD_ST_HOLD:    state_next = CFGD_ST_HOLD;
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			state_reg <= CFGD_ST_FILL;
		end else begin
			state_reg <= state_next;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			fill_cnt_reg <= 2'h0;
		end else if (state_reg == CFGD_ST_FILL && fill_cnt_reg != CFGD_FILL_CYC) begin
			fill_cnt_reg <= fill_cnt_reg + 2'h1;
		end
	end

	// R14 erased cells read as ones until captured
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			words_reg <= '1;
		end else if (state_reg == CFGD_ST_CAPTURE) begin
			words_reg <= sync_words;
		end
	end

	// R15 second core fields
	always_comb begin
		sec_decoded = '0;
		sec_decoded.initial_osc_source =
			osc_decode(words_reg.second_core_oscillator_select_word[CFGD_OSC_SRC_LSB +: 3]);
		sec_decoded.two_speed_startup_enable =
			words_reg.second_core_oscillator_select_word[CFGD_OSC_TWO_SPEED];
		sec_decoded.clock_switch_mode =
			words_reg.second_core_oscillator_word[CFGD_S_CKSM_LSB +: 2];
		sec_decoded.osc_pin_clock_out = words_reg.second_core_oscillator_word[CFGD_S_OSCIO];
		sec_decoded.second_core_no_boot_swap = words_reg.second_core_debug_word[CFGD_S_NO_SWAP];
		sec_decoded.second_core_isolation = words_reg.second_core_debug_word[CFGD_S_ISOLATE];
		sec_decoded.second_core_debug_channel =
			words_reg.second_core_debug_word[CFGD_S_DBG_LSB +: 2];
	end

	// R15 context assignments
	genvar gi;
	generate
		for (gi = 0; gi < CFGD_S_CTXT_COUNT; gi++) begin : g_ctxt
			always_ff @(posedge clk_sys) begin
				if (rst) begin
					sec_ctrl_reg.second_core_context_assign[gi] <= 3'h0;
				end else if (state_reg == CFGD_ST_DECODE) begin
					sec_ctrl_reg.second_core_context_assign[gi] <=
						words_reg.second_core_context_assign_word[gi*CFGD_S_CTXT_STRIDE +: 3];
				end
			end
		end
	endgenerate

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			sec_ctrl_reg.initial_osc_source        <= CFGD_OSC_FAST_RC;
			sec_ctrl_reg.two_speed_startup_enable  <= 1'b0;
			sec_ctrl_reg.clock_switch_mode         <= 2'h3;
			sec_ctrl_reg.osc_pin_clock_out         <= 1'b0;
			sec_ctrl_reg.second_core_no_boot_swap  <= 1'b0;
			sec_ctrl_reg.second_core_isolation     <= 1'b0;
			sec_ctrl_reg.second_core_debug_channel <= 2'h3;
		end else if (state_reg == CFGD_ST_DECODE) begin
			sec_ctrl_reg.initial_osc_source        <= sec_decoded.initial_osc_source;
			sec_ctrl_reg.two_speed_startup_enable  <= sec_decoded.two_speed_startup_enable;
			sec_ctrl_reg.clock_switch_mode         <= sec_decoded.clock_switch_mode;
			sec_ctrl_reg.osc_pin_clock_out         <= sec_decoded.osc_pin_clock_out;
			sec_ctrl_reg.second_core_no_boot_swap  <= sec_decoded.second_core_no_boot_swap;
			sec_ctrl_reg.second_core_isolation     <= sec_decoded.second_core_isolation;
			sec_ctrl_reg.second_core_debug_channel <= sec_decoded.second_core_debug_channel;
		end
	end

	// Until decode, hold everything protected: safer than trusting an erased view
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			prim_ctrl_reg.alternate_vector_table_enable   <= 1'b0;
			prim_ctrl_reg.cfg_segment_security_level      <= CFGD_SEC_HIGH;
			prim_ctrl_reg.cfg_segment_write_protected     <= 1'b1;
			prim_ctrl_reg.general_segment_security_level  <= CFGD_SEC_HIGH;
			prim_ctrl_reg.general_segment_write_protected <= 1'b1;
			prim_ctrl_reg.boot_segment_absent             <= 1'b1;
			prim_ctrl_reg.boot_segment_security_level     <= CFGD_SEC_HIGH;
			prim_ctrl_reg.boot_segment_write_protected    <= 1'b1;
			prim_ctrl_reg.boot_first_general_page         <= 13'h0000;
			prim_ctrl_reg.two_speed_startup_enable        <= 1'b0;
			prim_ctrl_reg.initial_osc_source              <= CFGD_OSC_FAST_RC;
		end else if (state_reg == CFGD_ST_DECODE) begin
			// R1 vector table
			prim_ctrl_reg.alternate_vector_table_enable <=
				~words_reg.code_protection_word[CFGD_SEC_ALTERNATE_VECTOR_TABLE_DIS];
			// R2 config level
			prim_ctrl_reg.cfg_segment_security_level <=
				level3(words_reg.code_protection_word[CFGD_SEC_CSS_LSB +: 3]);
			// R3 config protect
			prim_ctrl_reg.cfg_segment_write_protected <=
				~words_reg.code_protection_word[CFGD_SEC_CWP];
			// R4 general level
			prim_ctrl_reg.general_segment_security_level <=
				level2(words_reg.code_protection_word[CFGD_SEC_GSS_LSB +: 2]);
			// R5 general protect
			prim_ctrl_reg.general_segment_write_protected <=
				~words_reg.code_protection_word[CFGD_SEC_GWP];
			// R6 boot presence
			prim_ctrl_reg.boot_segment_absent <= words_reg.code_protection_word[CFGD_SEC_BABSENT];
			// R7 boot level
			prim_ctrl_reg.boot_segment_security_level <=
				level2(words_reg.code_protection_word[CFGD_SEC_BSS_LSB +: 2]);
			// R8 boot protect
			prim_ctrl_reg.boot_segment_write_protected <=
				~words_reg.code_protection_word[CFGD_SEC_BWP];
			// R6 R9 inverted limit
			if (words_reg.code_protection_word[CFGD_SEC_BABSENT]) begin
				prim_ctrl_reg.boot_first_general_page <= 13'h0000;
			end else begin
				prim_ctrl_reg.boot_first_general_page <=
					~words_reg.boot_limit_word[CFGD_BOOT_PAGE_LIMIT_INVERTED_MSB:0];
			end
			// R10 two-speed start
			prim_ctrl_reg.two_speed_startup_enable <=
				words_reg.oscillator_select_word[CFGD_OSC_TWO_SPEED];
			// R11 oscillator choice
			prim_ctrl_reg.initial_osc_source <=
				osc_decode(words_reg.oscillator_select_word[CFGD_OSC_SRC_LSB +: 3]);
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			valid_reg <= 1'b0;
		end else if (state_reg == CFGD_ST_DECODE) begin
			valid_reg <= 1'b1;
		end
	end

	assign status_clr_hit = bus_req.wr && bus_req.addr == CFGD_ADDR_STATUS;
	assign wr_other_hit   = bus_req.wr && bus_req.addr != CFGD_ADDR_STATUS;

	// R14 writes to words refused and flagged
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			wr_refused_reg <= 1'b0;
		end else if (wr_other_hit) begin
			wr_refused_reg <= 1'b1;
		end else if (status_clr_hit && bus_req.wdata[CFGD_ST_WR_REFUSED]) begin
			wr_refused_reg <= 1'b0;
		end
	end

	// R13 signature check; set wins over clear
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			sign_bad_reg <= 1'b0;
		end else if (state_reg == CFGD_ST_DECODE && words_reg.signature_word[CFGD_SIGN_RSVD]) begin
			sign_bad_reg <= 1'b1;
		end else if (status_clr_hit && bus_req.wdata[CFGD_ST_SIGN_BAD]) begin
			sign_bad_reg <= 1'b0;
		end
	end

	// R11 reserved oscillator codes flagged
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			osc_rsvd_reg   <= 1'b0;
			s_osc_rsvd_reg <= 1'b0;
		end else begin
			if (state_reg == CFGD_ST_DECODE && osc_decode(
					words_reg.oscillator_select_word[CFGD_OSC_SRC_LSB +: 3]) == CFGD_OSC_RESERVED) begin
				osc_rsvd_reg <= 1'b1;
			end else if (status_clr_hit && bus_req.wdata[CFGD_ST_OSC_RSVD]) begin
				osc_rsvd_reg <= 1'b0;
			end
			if (state_reg == CFGD_ST_DECODE && sec_decoded.initial_osc_source == CFGD_OSC_RESERVED) begin
				s_osc_rsvd_reg <= 1'b1;
			end else if (status_clr_hit && bus_req.wdata[CFGD_ST_S_OSC_RSVD]) begin
				s_osc_rsvd_reg <= 1'b0;
			end
		end
	end

	// R12 readback with unimplemented bits high
	always_comb begin
		rd_mux = '0;
		unique case (bus_req.addr)
			CFGD_ADDR_SEC:      rd_mux = readback(words_reg.code_protection_word, CFGD_IMPL_SEC);
			CFGD_ADDR_BOOT_PAGE_LIMIT_INVERTED:    rd_mux = readback(words_reg.boot_limit_word, CFGD_IMPL_BOOT_PAGE_LIMIT_INVERTED);
			CFGD_ADDR_SIGN:     rd_mux = readback(words_reg.signature_word, CFGD_IMPL_SIGN);
			CFGD_ADDR_OSCSEL:   rd_mux = readback(words_reg.oscillator_select_word, CFGD_IMPL_OSCSEL);
			CFGD_ADDR_S_OSCSEL: rd_mux = readback(words_reg.second_core_oscillator_select_word,
				CFGD_IMPL_OSCSEL);
			CFGD_ADDR_S_OSC:    rd_mux = readback(words_reg.second_core_oscillator_word, CFGD_IMPL_S_OSC);
			CFGD_ADDR_S_WDT:    rd_mux = readback(words_reg.second_core_watchdog_word, CFGD_IMPL_S_WDT);
			CFGD_ADDR_S_POR:    rd_mux = readback(words_reg.second_core_power_on_word, CFGD_IMPL_S_POR);
			CFGD_ADDR_S_DBG:    rd_mux = readback(words_reg.second_core_debug_word, CFGD_IMPL_S_DBG);
			CFGD_ADDR_S_DEVOPT: rd_mux = readback(words_reg.second_core_device_option_word,
				CFGD_IMPL_S_DEVOPT);
			CFGD_ADDR_S_CTXT:   rd_mux = readback(words_reg.second_core_context_assign_word,
				CFGD_IMPL_S_CTXT);
			CFGD_ADDR_STATUS: begin
				rd_mux[CFGD_ST_VALID]      = valid_reg;
				rd_mux[CFGD_ST_WR_REFUSED] = wr_refused_reg;
				rd_mux[CFGD_ST_SIGN_BAD]   = sign_bad_reg;
				rd_mux[CFGD_ST_OSC_RSVD]   = osc_rsvd_reg;
				rd_mux[CFGD_ST_S_OSC_RSVD] = s_osc_rsvd_reg;
			end
			default: rd_mux = '0;
		endcase
	end

	// Data only in the cycle after the strobe
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			bus_rdata_reg <= '0;
		end else if (bus_req.rd) begin
			bus_rdata_reg <= rd_mux;
		end else begin
			bus_rdata_reg <= '0;
		end
	end

	assign bus_rdata = bus_rdata_reg;
	assign prim_ctrl = prim_ctrl_reg;
	assign sec_ctrl  = sec_ctrl_reg;
	assign cfg_valid = valid_reg;

endmodule

// file: cfgd_decode_chk.sv
// Concurrent checks on the configuration word decoder top-level ports.
// Assumes fuse words stay static from reset until cfg_valid rises.
`timescale 1ns/100ps
module cfgd_decode_chk
	import cfgd_pkg::*;
(
	input wire logic            clk_sys,
	input wire logic            rst,
	input wire cfgd_words_s     cfg_words,
	input wire cfgd_bus_req_s   bus_req,
	input wire cfgd_word_t      bus_rdata,
	input wire cfgd_prim_ctrl_s prim_ctrl,
	input wire cfgd_sec_ctrl_s  sec_ctrl,
	input wire logic            cfg_valid
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	avt_map_a: assert property ($rose(cfg_valid) |->
		prim_ctrl.alternate_vector_table_enable == !cfg_words.code_protection_word[15])
		else $error("vector table enable does not follow its bit");
	wp_map_a: assert property ($rose(cfg_valid) |->
		{prim_ctrl.cfg_segment_write_protected, prim_ctrl.general_segment_write_protected,
		prim_ctrl.boot_segment_write_protected} == ~{cfg_words.code_protection_word[8],
		cfg_words.code_protection_word[5], cfg_words.code_protection_word[0]})
		else $error("write protect flags wrong");
	boot_map_a: assert property ($rose(cfg_valid) |->
		prim_ctrl.boot_segment_absent == cfg_words.code_protection_word[3] &&
		(cfg_words.code_protection_word[3] || prim_ctrl.boot_first_general_page == ~cfg_words.boot_limit_word[12:0]))
		else $error("boot segment decode wrong");
	start_map_a: assert property ($rose(cfg_valid) |->
		prim_ctrl.two_speed_startup_enable == cfg_words.oscillator_select_word[7] &&
		prim_ctrl.initial_osc_source == cfgd_osc_src_e'(~cfg_words.oscillator_select_word[2:0]))
		else $error("start-up clock decode wrong");
	// No slack on the last edge: cfg_valid first samples high on the later of the two edges
	valid_latency_a: assert property ($fell(rst) |-> !cfg_valid [*5] ##[1:2] cfg_valid)
		else $error("decode not ready in time");
	ctrl_hold_a: assert property (cfg_valid |=> cfg_valid && $stable(prim_ctrl) && $stable(sec_ctrl))
		else $error("decoded outputs moved after capture");
	rdata_idle_a: assert property (!bus_req.rd |=> bus_rdata == 24'h00_0000)
		else $error("read data outside read answer");
	sign_read_a: assert property (bus_req.rd && bus_req.addr == CFGD_ADDR_SIGN |=>
		bus_rdata[23:16] == 8'hFF && bus_rdata[14:0] == 15'h7FFF)
		else $error("unimplemented signature bits not one");

	cover property ($rose(cfg_valid));
	cover property (bus_req.wr && bus_req.addr != CFGD_ADDR_STATUS);
	cover property (bus_req.rd && bus_req.addr == CFGD_ADDR_STATUS);
endmodule

bind cfgd_decode cfgd_decode_chk cfgd_decode_chk_inst (.clk_sys(clk_sys), .rst(rst), .cfg_words(cfg_words),
	.bus_req(bus_req), .bus_rdata(bus_rdata), .prim_ctrl(prim_ctrl), .sec_ctrl(sec_ctrl), .cfg_valid(cfg_valid));

// file: test_config_word_decode.sv
// Self-checking bench for the configuration word decoder.
// Assumes the package and the bound checker are compiled first.
`timescale 1ns/100ps
module test_config_word_decode
	import cfgd_pkg::*;
;
	logic            clk_sys   = 1'b0;
	logic            rst       = 1'b1;
	cfgd_words_s     cfg_words = '1;
	cfgd_bus_req_s   bus_req   = '0;
	cfgd_word_t      bus_rdata;
	cfgd_prim_ctrl_s prim_ctrl;
	cfgd_sec_ctrl_s  sec_ctrl;
	logic            cfg_valid;
	int              bad_count = 0;
	int              checks    = 0;
	int              cycles    = 0;

	cfgd_decode cfgd_decode_inst (.clk_sys(clk_sys), .rst(rst), .cfg_words(cfg_words), .bus_req(bus_req),
		.bus_rdata(bus_rdata), .prim_ctrl(prim_ctrl), .sec_ctrl(sec_ctrl), .cfg_valid(cfg_valid));

	always #50 clk_sys = ~clk_sys;

	task automatic test_done();
		$display("Comparisons %0d, mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// Run is a few hundred cycles; the ceiling only cuts a hang
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 2000) begin
			bad_count++;
			test_done();
		end
	end

	task automatic chk(input logic [23:0] got, input logic [23:0] exp);
		checks++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	function automatic cfgd_sec_level_e lvl3(input logic [2:0] c);
		if (c == 3'h7) return CFGD_SEC_NONE;
		if (c == 3'h6) return CFGD_SEC_STANDARD;
		return c[2] ? CFGD_SEC_ENHANCED : CFGD_SEC_HIGH;
	endfunction

	function automatic cfgd_sec_level_e lvl2(input logic [1:0] c);
		if (c == 2'h3) return CFGD_SEC_NONE;
		return (c == 2'h2) ? CFGD_SEC_STANDARD : CFGD_SEC_HIGH;
	endfunction

	task automatic restart(input cfgd_words_s w);
		int n;
		@(posedge clk_sys);
		cfg_words <= w;
		rst       <= 1'b1;
		repeat (10) @(posedge clk_sys);
		rst <= 1'b0;
		n = 0;
		while (cfg_valid !== 1'b1 && n < 20) begin
			@(negedge clk_sys);
			n++;
		end
		chk(24'(cfg_valid), 24'h00_0001);
	endtask

	task automatic bus_wr(input cfgd_addr_t a, input cfgd_word_t d);
		@(posedge clk_sys);
		bus_req.addr  <= a;
		bus_req.wdata <= d;
		bus_req.wr    <= 1'b1;
		@(posedge clk_sys);
		bus_req.wr <= 1'b0;
	endtask

	task automatic bus_rd(input cfgd_addr_t a, input cfgd_word_t exp);
		@(posedge clk_sys);
		bus_req.addr <= a;
		bus_req.rd   <= 1'b1;
		@(posedge clk_sys);
		bus_req.rd <= 1'b0;
		@(negedge clk_sys);
		chk(bus_rdata, exp);
	endtask

	// Every level and source code plus the two-speed bit, other fields left erased
	task automatic level_sweep();
		cfgd_words_s w;
		for (int i = 0; i < 8; i++) begin
			w = '1;
			w.code_protection_word[11:9] = 3'(i);
			w.code_protection_word[7:6]  = 2'(i);
			w.code_protection_word[2:1]  = 2'(i);
			w.oscillator_select_word[2:0] = 3'(i);
			w.oscillator_select_word[7]   = i[0];
			restart(w);
			chk(24'(prim_ctrl.cfg_segment_security_level), 24'(lvl3(3'(i))));
			chk(24'(prim_ctrl.general_segment_security_level), 24'(lvl2(2'(i))));
			chk(24'(prim_ctrl.boot_segment_security_level), 24'(lvl2(2'(i))));
			chk(24'(prim_ctrl.initial_osc_source), 24'(7 - i));
			chk(24'(prim_ctrl.two_speed_startup_enable), 24'(i % 2));
			chk(24'(prim_ctrl.alternate_vector_table_enable), 24'h00_0000);
			chk(24'({prim_ctrl.cfg_segment_write_protected, prim_ctrl.general_segment_write_protected,
				prim_ctrl.boot_segment_write_protected}), 24'h00_0000);
			chk(24'({prim_ctrl.boot_segment_absent, prim_ctrl.boot_first_general_page}), 24'h00_2000);
			bus_rd(CFGD_ADDR_STATUS, (i == 4) ? 24'h00_000D : 24'h00_0005);
		end
	endtask

	// Programmed words, readback, refused writes and late changes
	task automatic programmed();
		cfgd_words_s w;
		w = '1;
		w.code_protection_word = 24'h00_0A82;
		w.boot_limit_word = 24'hFF_F0F0;
		w.signature_word = 24'hFF_7FFF;
		w.oscillator_select_word = 24'hFF_FF7C;
		w.second_core_oscillator_select_word = 24'hFF_FF7C;
		w.second_core_oscillator_word = 24'hFF_FF7B;
		w.second_core_debug_word = 24'hFF_DFFE;
		w.second_core_context_assign_word = 24'h00_1234;
		restart(w);
		chk(24'(prim_ctrl.alternate_vector_table_enable), 24'h00_0001);
		chk(24'({prim_ctrl.cfg_segment_write_protected, prim_ctrl.general_segment_write_protected,
			prim_ctrl.boot_segment_write_protected}), 24'h00_0007);
		chk(24'({prim_ctrl.boot_segment_absent, prim_ctrl.boot_first_general_page}), 24'h00_0F0F);
		chk(24'(sec_ctrl.initial_osc_source), 24'(CFGD_OSC_RESERVED));
		chk(24'({sec_ctrl.two_speed_startup_enable, sec_ctrl.clock_switch_mode, sec_ctrl.osc_pin_clock_out}),
			24'h00_0002);
		chk(24'({sec_ctrl.second_core_no_boot_swap, sec_ctrl.second_core_isolation,
			sec_ctrl.second_core_debug_channel}), 24'h00_000A);
		chk(24'(sec_ctrl.second_core_context_assign), 24'h00_029C);
		bus_rd(CFGD_ADDR_SEC, 24'hFF_7A92);
		bus_rd(CFGD_ADDR_SIGN, 24'hFF_7FFF);
		bus_rd(CFGD_ADDR_S_CTXT, 24'hFF_9ABC);
		bus_rd(CFGD_ADDR_STATUS, 24'h00_0019);
		bus_wr(CFGD_ADDR_SEC, 24'h00_0000);
		bus_rd(CFGD_ADDR_SEC, 24'hFF_7A92);
		bus_rd(CFGD_ADDR_STATUS, 24'h00_001B);
		bus_wr(CFGD_ADDR_STATUS, 24'h00_0002);
		bus_rd(CFGD_ADDR_STATUS, 24'h00_0019);
		bus_wr(CFGD_ADDR_STATUS, 24'h00_001C);
		bus_rd(CFGD_ADDR_STATUS, 24'h00_0001);
		bus_rd(8'h30, 24'h00_0000);
		@(posedge clk_sys);
		cfg_words.code_protection_word <= '1;
		repeat (10) @(posedge clk_sys);
		@(negedge clk_sys);
		chk(24'(prim_ctrl.alternate_vector_table_enable), 24'h00_0001);
		bus_rd(CFGD_ADDR_SEC, 24'hFF_7A92);
	endtask

	initial begin
		level_sweep();
		programmed();
		test_done();
	end
endmodule
